// ==== t2co_clk_sink.sv ====
`timescale 1ns/1ps
// load on the clock pin: keeps the length of the last high and low phase
module t2co_clk_sink (
  input  wire logic clk_i,
  input  wire logic pin_i,
  input  wire logic en_i,
  output int        hi_len_o,
  output int        lo_len_o
);
  int   run_len;
  logic last_lvl;
  always @(posedge clk_i) begin
    if (!en_i) begin
      run_len <= 0;
    end else if (pin_i != last_lvl) begin
      if (last_lvl) hi_len_o <= run_len;
      else lo_len_o <= run_len;
      run_len <= 1;
    end else begin
      run_len <= run_len + 1;
    end
    last_lvl <= pin_i;
  end
endmodule

// ==== t2co_clkout_gen.sv ====
`timescale 1ns/1ps

// clock pin driver: one toggle per overflow gives equal high and low phases
module t2co_clkout_gen (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic enable_i,
  input  wire logic overflow_i,
  output logic      clk_level_o
);

  logic next_level;

  always_comb begin
    next_level = clk_level_o;
    if (!enable_i) begin
      next_level = 1'b0;
    end else if (overflow_i) begin
      next_level = ~clk_level_o;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clk_level_o <= 1'b0;
    end else begin
      clk_level_o <= next_level;
    end
  end

endmodule

// ==== t2co_pkg.sv ====
package t2co_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // register byte addresses on the wishbone bus
  localparam logic [7:0] T2CO_CTRL_ADDR     = 8'hC8;
  localparam logic [7:0] T2CO_MODE_ADDR     = 8'hCC;
  localparam logic [7:0] T2CO_CNT_LO_ADDR   = 8'hD0;
  localparam logic [7:0] T2CO_CNT_HI_ADDR   = 8'hD4;
  localparam logic [7:0] T2CO_RLD_LO_ADDR   = 8'hD8;
  localparam logic [7:0] T2CO_RLD_HI_ADDR   = 8'hDC;
  localparam logic [7:0] T2CO_CTRL_SET_ADDR = 8'hE0;
  localparam logic [7:0] T2CO_CTRL_CLR_ADDR = 8'hE4;

  ////////////////////////////////////////////////////////////////////////////////
  // timer_two_control field positions
  localparam int T2CO_OVF_BIT     = 7;
  localparam int T2CO_EXT_BIT     = 6;
  localparam int T2CO_RXSEL_BIT   = 5;
  localparam int T2CO_TXSEL_BIT   = 4;
  localparam int T2CO_EXTEN_BIT   = 3;
  localparam int T2CO_RUN_BIT     = 2;
  localparam int T2CO_SRC_BIT     = 1;
  localparam int T2CO_CAPSEL_BIT  = 0;

  // timer_mode_register field positions
  localparam int T2CO_CLKOE_BIT   = 1;
  localparam int T2CO_UPDN_BIT    = 0;

  ////////////////////////////////////////////////////////////////////////////////
  // reset values, masks and limits
  localparam logic [7:0]  T2CO_CTRL_RESET   = 8'h00;
  localparam logic [7:0]  T2CO_MODE_RESET   = 8'h00;
  localparam logic [7:0]  T2CO_MODE_MASK    = 8'h03;
  localparam logic [15:0] T2CO_COUNT_RESET  = 16'h0000;
  localparam logic [15:0] T2CO_RELOAD_RESET = 16'h0000;
  localparam logic [15:0] T2CO_COUNT_MAX    = 16'hFFFF;
  localparam logic [15:0] T2CO_COUNT_ONE    = 16'h0001;
  localparam logic [15:0] T2CO_COUNT_WRAP   = 16'h0000;
  localparam logic [23:0] T2CO_RDATA_PAD    = 24'h000000;
  localparam logic [31:0] T2CO_RDATA_NONE   = 32'h00000000;

endpackage

// ==== t2co_sync_fall.sv ====
`timescale 1ns/1ps

// two-flop synchroniser with a falling-edge pulse taken after the second flop
module t2co_sync_fall (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic pin_i,
  output logic      fall_o
);

  logic meta;
  logic stable;
  logic last;
  logic next_fall;

  always_comb begin
    next_fall = last & ~stable;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta   <= 1'b1;
      stable <= 1'b1;
      last   <= 1'b1;
      fall_o <= 1'b0;
    end else begin
      meta   <= pin_i;
      stable <= meta;
      last   <= stable;
      fall_o <= next_fall;
    end
  end

endmodule

// ==== t2co_timer.sv ====
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - clock-out mode gives a 50% duty clock
// - clock-out count increments at half clock rate
// - overflow copies reload bytes into count bytes
// - no interrupt on overflow in clock-out mode
// - output frequency is clock over 4*(65536-reload)
// - generated clock is driven onto clock pin
// - baud generation and clock-out may run together
// - trigger event sets external flag, may interrupt
// - external flag never interrupts in up/down mode
// - receive baud select picks timer1 or timer2
// - transmit baud select picks timer1 or timer2
// - trigger edges act only if enabled, non-baud
// - run control stops or starts counting
// - source select picks internal clock or pin
// - baud or clock-out forces reload, else capture/reload select
// - control register resets zero, bit accessible
// - clock output enable makes pin an output
// - up/down enable bit is held in mode
module t2co_timer
  import t2co_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        timer_clock_pin_i,
  output logic             timer_clock_pin_o,
  output logic             timer_clock_pin_oe_o,
  input  wire logic        ext_trigger_pin_i,
  input  wire logic        timer1_overflow_i,
  input  wire logic        timer_irq_enable_i,
  output logic             timer_irq_o,
  output logic             rx_baud_clk_o,
  output logic             tx_baud_clk_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // state
  logic [7:0]  timer_control_register;
  logic [7:0]  timer_mode_register;
  logic [15:0] count;
  logic [15:0] reload;
  logic        phase;

  logic [7:0]  next_timer_control_register;
  logic [7:0]  next_timer_mode_register;
  logic [15:0] next_count;
  logic [15:0] next_reload;
  logic        next_phase;
  logic [31:0] next_wb_dat;
  logic        next_wb_ack;
  logic        next_timer_irq;
  logic        next_rx_baud_clk;
  logic        next_tx_baud_clk;

  ////////////////////////////////////////////////////////////////////////////////
  // field views
  logic overflow_flag;
  logic external_event_flag;
  logic rx_baud_source_sel;
  logic tx_baud_source_sel;
  logic ext_trigger_enable;
  logic run_control;
  logic count_source_sel;
  logic capture_reload_sel;
  logic clock_output_enable;
  logic updown_enable;

  assign overflow_flag       = timer_control_register[T2CO_OVF_BIT];
  assign external_event_flag = timer_control_register[T2CO_EXT_BIT];
  assign rx_baud_source_sel  = timer_control_register[T2CO_RXSEL_BIT];
  assign tx_baud_source_sel  = timer_control_register[T2CO_TXSEL_BIT];
  assign ext_trigger_enable  = timer_control_register[T2CO_EXTEN_BIT];
  assign run_control         = timer_control_register[T2CO_RUN_BIT];
  assign count_source_sel    = timer_control_register[T2CO_SRC_BIT];
  assign capture_reload_sel  = timer_control_register[T2CO_CAPSEL_BIT];
  assign clock_output_enable = timer_mode_register[T2CO_CLKOE_BIT];
  assign updown_enable       = timer_mode_register[T2CO_UPDN_BIT];

  ////////////////////////////////////////////////////////////////////////////////
  // pin inputs, synchronised before use
  logic pin_fall;
  logic trigger_fall;

  t2co_sync_fall u_pin_sync (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .pin_i  (timer_clock_pin_i),
    .fall_o (pin_fall)
  );

  t2co_sync_fall u_trigger_sync (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .pin_i  (ext_trigger_pin_i),
    .fall_o (trigger_fall)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // timer core decisions
  logic baud_mode;
  logic count_tick;
  logic overflow;
  logic ext_event;
  logic force_reload;

  always_comb begin
    baud_mode    = rx_baud_source_sel | tx_baud_source_sel;
    // internal source ticks every second clock, pin source on each falling edge
    count_tick   = run_control & (count_source_sel ? pin_fall : phase);
    overflow     = count_tick & (count == T2CO_COUNT_MAX);
    // a serial-clocking timer ignores the trigger pin altogether
    ext_event    = ext_trigger_enable & trigger_fall & ~baud_mode;
    // clock-out must keep reloading even if capture was left selected
    force_reload = baud_mode | clock_output_enable | ~capture_reload_sel;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // wishbone decode
  logic       wb_hit;
  logic       wb_write;
  logic [7:0] wb_byte;

  assign wb_hit   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wb_write = wb_hit & wb_we_i & wb_sel_i[0];
  assign wb_byte  = wb_dat_i[7:0];

  ////////////////////////////////////////////////////////////////////////////////
  // count and reload
  always_comb begin
    next_phase  = ~phase;
    next_count  = count;
    next_reload = reload;

    // counting, reload and capture
    if (overflow) begin
      if (force_reload) begin
        next_count = reload;
      end else begin
        next_count = T2CO_COUNT_WRAP;
      end
    end else if (count_tick) begin
      next_count = count + T2CO_COUNT_ONE;
    end
    if (ext_event) begin
      if (capture_reload_sel && !clock_output_enable) begin
        next_reload = count;
      end else begin
        next_count = reload;
      end
    end

    // a software write wins over a tick or reload in the same cycle
    if (wb_write) begin
      if (wb_adr_i == T2CO_CNT_LO_ADDR) begin
        next_count[7:0] = wb_byte;
      end else if (wb_adr_i == T2CO_CNT_HI_ADDR) begin
        next_count[15:8] = wb_byte;
      end else if (wb_adr_i == T2CO_RLD_LO_ADDR) begin
        next_reload[7:0] = wb_byte;
      end else if (wb_adr_i == T2CO_RLD_HI_ADDR) begin
        next_reload[15:8] = wb_byte;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count  <= T2CO_COUNT_RESET;
      reload <= T2CO_RELOAD_RESET;
      phase  <= 1'b0;
    end else begin
      count  <= next_count;
      reload <= next_reload;
      phase  <= next_phase;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // control and mode; one aligned word per register, low byte lane only
  always_comb begin
    next_timer_control_register = timer_control_register;
    next_timer_mode_register    = timer_mode_register;
    if (wb_write) begin
      if (wb_adr_i == T2CO_CTRL_ADDR) begin
        next_timer_control_register = wb_byte;
      end else if (wb_adr_i == T2CO_CTRL_SET_ADDR) begin
        next_timer_control_register = timer_control_register | wb_byte;
      end else if (wb_adr_i == T2CO_CTRL_CLR_ADDR) begin
        next_timer_control_register = timer_control_register & ~wb_byte;
      end else if (wb_adr_i == T2CO_MODE_ADDR) begin
        next_timer_mode_register = wb_byte & T2CO_MODE_MASK;
      end
    end

    // hardware sets win over a software clear in the same cycle
    if (overflow && !baud_mode) begin
      next_timer_control_register[T2CO_OVF_BIT] = 1'b1;
    end
    if (ext_event) begin
      next_timer_control_register[T2CO_EXT_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timer_control_register <= T2CO_CTRL_RESET;
      timer_mode_register    <= T2CO_MODE_RESET;
    end else begin
      timer_control_register <= next_timer_control_register;
      timer_mode_register    <= next_timer_mode_register;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // bus answer; the standing ack masks a second take of the same request
  always_comb begin
    next_wb_ack = wb_hit;
    next_wb_dat = wb_dat_o;

    // read data; unmapped addresses answer with zero
    if (wb_hit && !wb_we_i) begin
      if (wb_adr_i == T2CO_CTRL_ADDR) begin
        next_wb_dat = {T2CO_RDATA_PAD, timer_control_register};
      end else if (wb_adr_i == T2CO_CTRL_SET_ADDR) begin
        next_wb_dat = {T2CO_RDATA_PAD, timer_control_register};
      end else if (wb_adr_i == T2CO_CTRL_CLR_ADDR) begin
        next_wb_dat = {T2CO_RDATA_PAD, timer_control_register};
      end else if (wb_adr_i == T2CO_MODE_ADDR) begin
        next_wb_dat = {T2CO_RDATA_PAD, timer_mode_register};
      end else if (wb_adr_i == T2CO_CNT_LO_ADDR) begin
        next_wb_dat = {T2CO_RDATA_PAD, count[7:0]};
      end else if (wb_adr_i == T2CO_CNT_HI_ADDR) begin
        next_wb_dat = {T2CO_RDATA_PAD, count[15:8]};
      end else if (wb_adr_i == T2CO_RLD_LO_ADDR) begin
        next_wb_dat = {T2CO_RDATA_PAD, reload[7:0]};
      end else if (wb_adr_i == T2CO_RLD_HI_ADDR) begin
        next_wb_dat = {T2CO_RDATA_PAD, reload[15:8]};
      end else begin
        next_wb_dat = T2CO_RDATA_NONE;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= T2CO_RDATA_NONE;
      wb_ack_o <= 1'b0;
    end else begin
      wb_dat_o <= next_wb_dat;
      wb_ack_o <= next_wb_ack;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs towards interrupt controller and serial port
  always_comb begin
    // overflow never interrupts while the pin is a clock output
    next_timer_irq   = timer_irq_enable_i &
                       ((overflow_flag & ~clock_output_enable) |
                        (external_event_flag & ~updown_enable));
    next_rx_baud_clk = rx_baud_source_sel ? overflow : timer1_overflow_i;
    next_tx_baud_clk = tx_baud_source_sel ? overflow : timer1_overflow_i;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // registered outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timer_irq_o   <= 1'b0;
      rx_baud_clk_o <= 1'b0;
      tx_baud_clk_o <= 1'b0;
    end else begin
      timer_irq_o   <= next_timer_irq;
      rx_baud_clk_o <= next_rx_baud_clk;
      tx_baud_clk_o <= next_tx_baud_clk;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // clock pin driver
  t2co_clkout_gen u_clkout (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .enable_i    (clock_output_enable),
    .overflow_i  (overflow),
    .clk_level_o (timer_clock_pin_o)
  );

  // the pin is an input whenever clock output is off
  assign timer_clock_pin_oe_o = clock_output_enable;

endmodule

// ==== t2co_timer_chk.sv ====
`timescale 1ns/1ps
module t2co_timer_chk (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        timer_clock_pin_o,
  input wire logic        timer_clock_pin_oe_o,
  input wire logic        timer_irq_enable_i,
  input wire logic        timer_irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////////////////////
  property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("no ack after request");
  property p_ack1; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack1: assert property (p_ack1) else $error("ack held too long");
  property p_ackreq; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i); endproperty
  a_ackreq: assert property (p_ackreq) else $error("ack without request");
  property p_pad; wb_ack_o |-> wb_dat_o[31:8] == 24'h000000; endproperty
  a_pad: assert property (p_pad) else $error("read data upper bits set");
  // one cycle of slack: pin and enable are registered apart
  property p_off; !timer_clock_pin_oe_o && $past(!timer_clock_pin_oe_o) |-> !timer_clock_pin_o;
  endproperty
  a_off: assert property (p_off) else $error("pin driven while disabled");
  property p_duty;
    $changed(timer_clock_pin_o) && timer_clock_pin_oe_o
      |=> $stable(timer_clock_pin_o) || !timer_clock_pin_oe_o;
  endproperty
  a_duty: assert property (p_duty) else $error("clock phase shorter than two");
  property p_irq; !timer_irq_enable_i && $past(!timer_irq_enable_i) |-> !timer_irq_o; endproperty
  a_irq: assert property (p_irq) else $error("irq while disabled");
  property p_oe; $changed(timer_clock_pin_oe_o) |-> wb_ack_o || $past(wb_ack_o); endproperty
  a_oe: assert property (p_oe) else $error("pin direction moved without write");
endmodule
bind t2co_timer t2co_timer_chk chk_u (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .timer_clock_pin_o(timer_clock_pin_o),
  .timer_clock_pin_oe_o(timer_clock_pin_oe_o), .timer_irq_enable_i(timer_irq_enable_i),
  .timer_irq_o(timer_irq_o));

// ==== timer2_clock_out_control_tb_top.sv ====
`timescale 1ns/1ps
module timer2_clock_out_control_tb_top;
  import t2co_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h00000000;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [3:0]  sel_lanes = 4'hF;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o, pin_o, pin_oe, irq, rx_b, tx_b, pin_w;
  logic        drv = 1'b1;
  logic        trig = 1'b1;
  logic        t1_ovf = 1'b0;
  logic        irq_en = 1'b0;
  int          n_fail = 0;
  int          samples_checked = 0;
  int          hi_len, lo_len;
  always #2.5 clk_i = ~clk_i;
  // pin wire: the timer wins while it drives, else the bench source
  assign pin_w = pin_oe ? pin_o : drv;
  t2co_timer dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .timer_clock_pin_i(pin_w),
    .timer_clock_pin_o(pin_o), .timer_clock_pin_oe_o(pin_oe), .ext_trigger_pin_i(trig),
    .timer1_overflow_i(t1_ovf), .timer_irq_enable_i(irq_en), .timer_irq_o(irq),
    .rx_baud_clk_o(rx_b), .tx_baud_clk_o(tx_b));
  t2co_clk_sink sink_u (.clk_i(clk_i), .pin_i(pin_w), .en_i(pin_oe), .hi_len_o(hi_len),
    .lo_len_o(lo_len));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
                    output logic [31:0] r);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_sel_i <= sel_lanes;
    wb_dat_i <= {24'h000000, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      chk("ack", 32'h00000000, 32'h00000001);
      end_sim();
    end
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    wb(1'b1, a, d, r);
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e, input string nm);
    logic [31:0] r;
    wb(1'b0, a, 8'h00, r);
    chk(nm, r, {24'h000000, e});
  endtask
  task automatic fall_trig();
    trig <= 1'b0;
    repeat (8) @(posedge clk_i);
    trig <= 1'b1;
    repeat (8) @(posedge clk_i);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reg();
    rc(T2CO_CTRL_ADDR, 8'h00, "ctrl");
    rc(T2CO_MODE_ADDR, 8'h00, "mode");
    rc(8'hF0, 8'h00, "unmapped");
    wr(T2CO_CTRL_SET_ADDR, 8'h08);
    rc(T2CO_CTRL_ADDR, 8'h08, "setbit");
    wr(T2CO_CTRL_CLR_ADDR, 8'h08);
    rc(T2CO_CTRL_ADDR, 8'h00, "clrbit");
    sel_lanes = 4'hE;
    wr(T2CO_CTRL_ADDR, 8'h08);
    sel_lanes = 4'hF;
    rc(T2CO_CTRL_ADDR, 8'h00, "nolane");
    wr(T2CO_MODE_ADDR, 8'hFF);
    rc(T2CO_MODE_ADDR, 8'h03, "modebits");
    $display("done t_reg");
  endtask
  task automatic t_clkout();
    wr(T2CO_MODE_ADDR, 8'h02);
    wr(T2CO_RLD_LO_ADDR, 8'hF0);
    wr(T2CO_RLD_HI_ADDR, 8'hFF);
    wr(T2CO_CNT_LO_ADDR, 8'hF0);
    wr(T2CO_CNT_HI_ADDR, 8'hFF);
    wr(T2CO_CTRL_ADDR, 8'h04);
    irq_en <= 1'b1;
    repeat (400) @(posedge clk_i);
    chk("high", hi_len, 32);
    chk("low", lo_len, 32);
    chk("irq", irq, 0);
    chk("oe", pin_oe, 1);
    rc(T2CO_CTRL_ADDR, 8'h84, "ovf");
    rc(T2CO_CNT_HI_ADDR, 8'hFF, "cnthi");
    $display("done t_clkout");
  endtask
  task automatic t_baud();
    int n;
    n = 0;
    wr(T2CO_CTRL_ADDR, 8'h34);
    wr(T2CO_CTRL_CLR_ADDR, 8'h80);
    repeat (128) begin
      @(posedge clk_i);
      n += rx_b + tx_b;
    end
    chk("baud", n, 8);
    chk("both", hi_len, 32);
    rc(T2CO_CTRL_ADDR, 8'h34, "noovf");
    wr(T2CO_CTRL_ADDR, 8'h04);
    t1_ovf <= 1'b1;
    @(posedge clk_i);
    t1_ovf <= 1'b0;
    @(posedge clk_i);
    chk("rx1", rx_b, 1);
    chk("tx1", tx_b, 1);
    $display("done t_baud");
  endtask
  task automatic t_trig();
    logic [7:0] cf[2];
    cf = '{8'h00, 8'h18};
    wr(T2CO_CTRL_ADDR, 8'h00);
    wr(T2CO_MODE_ADDR, 8'h00);
    chk("oeoff", pin_oe, 0);
    wr(T2CO_CNT_LO_ADDR, 8'h05);
    wr(T2CO_CTRL_ADDR, 8'h08);
    fall_trig();
    rc(T2CO_CTRL_ADDR, 8'h48, "extflag");
    rc(T2CO_CNT_LO_ADDR, 8'hF0, "reload");
    chk("irqext", irq, 1);
    wr(T2CO_MODE_ADDR, 8'h01);
    repeat (2) @(posedge clk_i);
    chk("irqupdn", irq, 0);
    wr(T2CO_CTRL_ADDR, 8'h09);
    wr(T2CO_CNT_LO_ADDR, 8'h33);
    fall_trig();
    rc(T2CO_RLD_LO_ADDR, 8'h33, "capture");
    for (int i = 0; i < 2; i++) begin
      wr(T2CO_CTRL_ADDR, cf[i]);
      wr(T2CO_CNT_LO_ADDR, 8'h44);
      fall_trig();
      rc(T2CO_CNT_LO_ADDR, 8'h44, "ignored");
      rc(T2CO_CTRL_ADDR, cf[i], "noflag");
    end
    $display("done t_trig");
  endtask
  task automatic t_src();
    wr(T2CO_CTRL_ADDR, 8'h00);
    wr(T2CO_CNT_LO_ADDR, 8'h00);
    wr(T2CO_CTRL_ADDR, 8'h06);
    repeat (3) begin
      drv <= 1'b0;
      repeat (6) @(posedge clk_i);
      drv <= 1'b1;
      repeat (6) @(posedge clk_i);
    end
    wr(T2CO_CTRL_ADDR, 8'h00);
    repeat (20) @(posedge clk_i);
    rc(T2CO_CNT_LO_ADDR, 8'h03, "pincount");
    $display("done t_src");
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reg();
    t_clkout();
    t_baud();
    t_trig();
    t_src();
    end_sim();
  end
endmodule
